// file: dv/odt_ctrl_assertions.sv
// Port level assertions of the termination controller.
module odt_ctrl_assertions (
  // Clocks and reset.
  input wire logic       I_CLOCK,
  input wire logic       I_RST_N,
  input wire logic       I_CK,
  // Register bus handshakes.
  input wire logic       I_AWVALID,
  input wire logic       O_AWREADY,
  input wire logic       I_WVALID,
  input wire logic       O_WREADY,
  input wire logic       O_BVALID,
  input wire logic       I_ARVALID,
  input wire logic       O_ARREADY,
  input wire logic       O_RVALID,
  // Termination state.
  input wire logic       O_TERM_HIZ,
  input wire logic       O_TERM_WR,
  input wire logic       O_TERM_NOM,
  input wire logic       O_TERM_PARK,
  input wire logic [2:0] O_RTT_CODE,
  input wire logic       O_TDQS_TERM,
  input wire logic       O_ODT_RX_EN
);
  timeunit 1ns;
  timeprecision 100ps;

  term_onehot_a: assert property (@(posedge I_CK) disable iff (!I_RST_N)
    $onehot({O_TERM_HIZ, O_TERM_WR, O_TERM_NOM, O_TERM_PARK})) else $error("state not one-hot");
  hiz_code_a: assert property (@(posedge I_CK) disable iff (!I_RST_N)
    O_TERM_HIZ |-> O_RTT_CODE == 3'h0) else $error("code set while off");
  on_code_a: assert property (@(posedge I_CK) disable iff (!I_RST_N)
    !O_TERM_HIZ |-> O_RTT_CODE != 3'h0) else $error("termination on with zero code");
  wr_code_a: assert property (@(posedge I_CK) disable iff (!I_RST_N)
    O_TERM_WR |-> O_RTT_CODE inside {[3'h1:3'h3]}) else $error("write code out of range");
  tdqs_off_a: assert property (@(posedge I_CK) disable iff (!I_RST_N)
    O_TDQS_TERM |-> !O_TERM_HIZ) else $error("strobe pair terminated while off");
  nom_rx_a: assert property (@(posedge I_CK) disable iff (!I_RST_N)
    O_TERM_NOM |-> $past(O_ODT_RX_EN)) else $error("nominal without pin receiver");
  wr_answer_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    I_AWVALID && O_AWREADY && I_WVALID && O_WREADY |-> ##[1:3] O_BVALID)
    else $error("write response late");
  wr_refuse_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    O_BVALID |-> !O_AWREADY && !O_WREADY) else $error("write taken during response");
  rd_answer_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    I_ARVALID && O_ARREADY |=> O_RVALID) else $error("read response late");
  rd_refuse_a: assert property (@(posedge I_CLOCK) disable iff (!I_RST_N)
    O_RVALID |-> !O_ARREADY) else $error("read taken during response");
endmodule

bind odt_ctrl odt_ctrl_assertions i_chk (.I_CLOCK, .I_RST_N, .I_CK, .I_AWVALID, .O_AWREADY,
  .I_WVALID, .O_WREADY, .O_BVALID, .I_ARVALID, .O_ARREADY, .O_RVALID, .O_TERM_HIZ, .O_TERM_WR,
  .O_TERM_NOM, .O_TERM_PARK, .O_RTT_CODE, .O_TDQS_TERM, .O_ODT_RX_EN);

// file: dv/odt_host_model.sv
// Behavioural memory controller driving the termination pin and commands.
module odt_host_model (
  // Link clock.
  input  wire logic i_ck,
  // Termination pin and one-cycle command strobes.
  output logic      o_odt = 1'b0,
  output logic      o_wr  = 1'b0,
  output logic      o_rd  = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;

  // Issues a command and a pin pulse starting at the same edge.
  task automatic issue(input int odt_n, input bit w, input bit r);
    int h;
    h = (odt_n > 0 && odt_n < 7) ? 7 : odt_n;
    @(posedge i_ck);
    o_odt <= (h > 0);
    o_wr <= w;
    o_rd <= r;
    @(posedge i_ck);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    repeat ((h > 1) ? h - 1 : 0) @(posedge i_ck);
    o_odt <= 1'b0;
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench of the termination controller.
module tb_top
  import odt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0, ck = 1'b0, rst_n = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [3:0]  wstrb = 4'hf;
  logic [31:0] wdata = '0, rdata;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic        odt, cwr, crd, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic        hiz, twr, nom, park, tdqs, rxen;
  logic [1:0]  bresp, rresp;
  logic [2:0]  code;
  logic [2:0]  hist[$];
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  int          c_nom = 0, c_wr = 0, c_park = 0, c_sr = 0, c_tdqs = 0, c_pre = 0, c_bl8 = 0;
  int          c_wl = 9, c_rl = 11;
  bit          chk_on = 1'b0;

  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #24 ck = ~ck;
  end

  odt_ctrl i_dut (.I_CLOCK(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awv),
    .O_AWREADY(awrdy), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wv), .O_WREADY(wrdy),
    .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arv), .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready), .I_CK(ck), .I_ODT(odt), .I_CMD_WRITE(cwr), .I_CMD_READ(crd),
    .O_TERM_HIZ(hiz), .O_TERM_WR(twr), .O_TERM_NOM(nom), .O_TERM_PARK(park),
    .O_RTT_CODE(code), .O_TDQS_TERM(tdqs), .O_ODT_RX_EN(rxen));
  odt_host_model i_host (.i_ck(ck), .o_odt(odt), .o_wr(cwr), .o_rd(crd));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Expected {tdqs, rx_en, code, onehot} for read, write and pin activity.
  function automatic logic [8:0] exp_vec(bit r, bit w, bit o);
    int s, c;
    s = 0;
    c = 0;
    if (c_sr || r) s = 0;
    else if (w && c_wr != 0) s = 1;
    else if (o && c_nom != 0) s = 2;
    else if (c_park != 0) s = 3;
    c = (s == 1) ? c_wr : (s == 2) ? c_nom : (s == 3) ? c_park : 0;
    return {c_tdqs != 0 && s != 0, c_nom != 0 && c_sr == 0, 3'(c), 4'(1 << s)};
  endfunction

  always @(posedge ck) hist.push_back({odt, cwr, crd});
  always @(negedge ck) begin
    int n, x, lw, lr, ln;
    bit r, w, o;
    n = hist.size() - 1;
    x = c_pre ? 3 : 2;
    ln = (c_bl8 ? 4 : 2) + x;
    lw = (c_wl > x) ? c_wl - x : 0;
    lr = (c_rl > x) ? c_rl - x : 0;
    r = 0;
    w = 0;
    for (int k = n - ln + 1; k <= n; k++) begin
      if (k - lr - 1 >= 0 && hist[k - lr - 1][0]) r = 1;
      if (k - lw - 1 >= 0 && hist[k - lw - 1][1]) w = 1;
    end
    o = (n - lw - 1 >= 0) && hist[n - lw - 1][2];
    if (chk_on) check(32'({tdqs, rxen, code, park, nom, twr, hiz}), 32'(exp_vec(r, w, o)));
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit ta, tw, done;
    logic [1:0] rs;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awrdy;
      tw = wv && wrdy;
      done = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!done);
    bready <= 1'b0;
    check(32'(rs), 32'(er));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    bit ta, done;
    logic [31:0] d;
    logic [1:0] rs;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv && arrdy;
      done = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!done);
    rready <= 1'b0;
    check({d[29:0], rs}, {ed[29:0], er});
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    int k;
    logic [31:0] rtt;
    logic [8:0]  ev;
    void'($urandom(34));
    repeat (3) @(posedge clk);
    repeat (2) @(posedge ck);
    @(posedge clk) rst_n <= 1'b1;
    axi_rd(OFS_CTRL, 32'h0, RESP_OKAY);
    axi_rd(OFS_RTT, 32'h0, RESP_OKAY);
    axi_rd(OFS_LAT, {18'h0, RL_RST, 2'h0, WL_RST}, RESP_OKAY);
    axi_wr(8'h10, 32'hffff_ffff, RESP_SLVERR);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    // Only byte lane 1 is enabled, so just the park field may change.
    wstrb <= 4'h2;
    axi_wr(OFS_RTT, 32'hffff_ffff, RESP_OKAY);
    wstrb <= 4'hf;
    axi_rd(OFS_RTT, 32'h0000_0700, RESP_OKAY);
    for (int i = 0; i < 12; i++) begin
      chk_on = 1'b0;
      c_nom = $urandom % 8;
      c_wr = $urandom % 4;
      c_park = $urandom % 8;
      c_sr = ($urandom % 5) == 0;
      c_tdqs = $urandom % 2;
      c_pre = $urandom % 2;
      c_bl8 = $urandom % 2;
      c_wl = 5 + $urandom % 16;
      c_rl = 5 + $urandom % 16;
      rtt = 32'((c_park << RTT_PARK_LSB) | (c_wr << RTT_WR_LSB) | c_nom);
      axi_wr(OFS_RTT, rtt, RESP_OKAY);
      axi_wr(OFS_LAT, 32'((c_rl << LAT_RL_LSB) | c_wl), RESP_OKAY);
      axi_wr(OFS_CTRL, 32'(c_bl8 * 8 + c_pre * 4 + c_tdqs * 2 + c_sr), RESP_OKAY);
      repeat (30) @(posedge ck);
      chk_on = 1'b1;
      axi_rd(OFS_RTT, rtt, RESP_OKAY);
      ev = exp_vec(0, 0, 0);
      // Status word holds the one-hot state on top, then the code, then the receiver enable.
      axi_rd(OFS_STATUS, 32'({ev[3:0], ev[6:4], ev[7]}), RESP_OKAY);
      repeat (8) begin
        k = $urandom % 4;
        i_host.issue(k[0] ? 1 + $urandom % 10 : 0, k[1], k == 0);
        repeat ($urandom % 4) @(posedge ck);
      end
      repeat (30) @(posedge ck);
    end
    print_verdict();
  end
endmodule

// file: rtl/odt_ctrl.sv
// On-die termination controller with AXI4-Lite registers and a link clock domain.
module odt_ctrl
  import odt_pkg::*;
(
  // Register clock and reset.
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  // AXI4-Lite write response.
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read.
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Link clock, ODT pin and decoded commands.
  input  wire logic        I_CK,
  input  wire logic        I_ODT,
  input  wire logic        I_CMD_WRITE,
  input  wire logic        I_CMD_READ,
  // Termination state towards the lane drivers.
  output logic             O_TERM_HIZ,
  output logic             O_TERM_WR,
  output logic             O_TERM_NOM,
  output logic             O_TERM_PARK,
  output logic [2:0]       O_RTT_CODE,
  output logic             O_TDQS_TERM,
  output logic             O_ODT_RX_EN
);

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    cfg_t        cfg;
    cfg_t        cfg_send;
    logic        req_tgl;
    stat_t       status;
  } sys_st_t;

  typedef struct packed {
    cfg_t      cfg;
    logic      ack_tgl;
    stat_t     hold;
    term_sel_t sel;
    logic [2:0] code;
    logic      tdqs;
  } ck_st_t;

  sys_st_t sys_ff;
  sys_st_t nxt_sys;
  ck_st_t  ck_ff;
  ck_st_t  nxt_ck;

  logic       req_sync;
  logic       ack_sync;
  logic       rd_off;
  logic       wr_on;
  logic       nom_on;
  logic       nom_en;
  logic       wr_en;
  logic       park_en;
  logic [1:0] pre_x;
  logic [3:0] burst_len;
  logic [5:0] odt_lat;
  logic [5:0] rd_lat;

  // Latency less the preamble offset, held at zero when the latency is too short.
  function automatic logic [5:0] sat_sub(input logic [5:0] lat, input logic [1:0] x);
    logic [5:0] res;
    res = (lat > {4'h0, x}) ? lat - {4'h0, x} : 6'h00;
    return res;
  endfunction

  function automatic logic [31:0] read_word(input sys_st_t s, input logic [7:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      OFS_CTRL: begin
        w[CTRL_SELF_REFRESH] = s.cfg.self_refresh;
        w[CTRL_TDQS_EN]      = s.cfg.tdqs_en;
        w[CTRL_PREAMBLE2]    = s.cfg.preamble2;
        w[CTRL_BL8]          = s.cfg.bl8;
      end
      OFS_RTT: begin
        w[RTT_NOM_LSB +: 3]  = s.cfg.rtt_nom;
        w[RTT_WR_LSB +: 2]   = s.cfg.rtt_wr;
        w[RTT_PARK_LSB +: 3] = s.cfg.rtt_park;
      end
      OFS_LAT: begin
        w[LAT_WL_LSB +: 6] = s.cfg.wl;
        w[LAT_RL_LSB +: 6] = s.cfg.rl;
      end
      OFS_STATUS: begin
        w[7:0] = s.status;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  function automatic logic addr_known(input logic [7:0] addr);
    return (addr == OFS_CTRL) || (addr == OFS_RTT) || (addr == OFS_LAT) ||
           (addr == OFS_STATUS);
  endfunction

  // Register domain: AXI slave and the configuration/status handshake.
  assign O_AWREADY = !sys_ff.aw_got && !sys_ff.bvalid;
  assign O_WREADY  = !sys_ff.w_got && !sys_ff.bvalid;
  assign O_ARREADY = !sys_ff.rvalid;
  assign O_BVALID  = sys_ff.bvalid;
  assign O_BRESP   = sys_ff.bresp;
  assign O_RVALID  = sys_ff.rvalid;
  assign O_RDATA   = sys_ff.rdata;
  assign O_RRESP   = sys_ff.rresp;

  always_comb begin
    nxt_sys = sys_ff;
    if (I_AWVALID && O_AWREADY) begin
      nxt_sys.aw_got = 1'b1;
      nxt_sys.awaddr = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      nxt_sys.w_got = 1'b1;
      nxt_sys.wdata = I_WDATA;
      nxt_sys.wstrb = I_WSTRB;
    end
    if (sys_ff.aw_got && sys_ff.w_got) begin
      nxt_sys.aw_got = 1'b0;
      nxt_sys.w_got  = 1'b0;
      nxt_sys.bvalid = 1'b1;
      nxt_sys.bresp  = addr_known(sys_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (sys_ff.awaddr)
        OFS_CTRL: begin
          if (sys_ff.wstrb[0]) begin
            nxt_sys.cfg.self_refresh = sys_ff.wdata[CTRL_SELF_REFRESH];
            nxt_sys.cfg.tdqs_en      = sys_ff.wdata[CTRL_TDQS_EN];
            nxt_sys.cfg.preamble2    = sys_ff.wdata[CTRL_PREAMBLE2];
            nxt_sys.cfg.bl8          = sys_ff.wdata[CTRL_BL8];
          end
        end
        OFS_RTT: begin
          if (sys_ff.wstrb[0]) begin
            nxt_sys.cfg.rtt_nom = sys_ff.wdata[RTT_NOM_LSB +: 3];
            nxt_sys.cfg.rtt_wr  = sys_ff.wdata[RTT_WR_LSB +: 2];
          end
          if (sys_ff.wstrb[1]) begin
            nxt_sys.cfg.rtt_park = sys_ff.wdata[RTT_PARK_LSB +: 3];
          end
        end
        OFS_LAT: begin
          if (sys_ff.wstrb[0]) begin
            nxt_sys.cfg.wl = sys_ff.wdata[LAT_WL_LSB +: 6];
          end
          if (sys_ff.wstrb[1]) begin
            nxt_sys.cfg.rl = sys_ff.wdata[LAT_RL_LSB +: 6];
          end
        end
        default: begin
          nxt_sys.cfg = sys_ff.cfg;
        end
      endcase
    end
    if (sys_ff.bvalid && I_BREADY) begin
      nxt_sys.bvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      nxt_sys.rvalid = 1'b1;
      nxt_sys.rdata  = read_word(sys_ff, I_ARADDR);
      nxt_sys.rresp  = addr_known(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end else if (sys_ff.rvalid && I_RREADY) begin
      nxt_sys.rvalid = 1'b0;
    end
    // Each completed exchange picks up the status and sends the latest settings.
    if (ack_sync == sys_ff.req_tgl) begin
      nxt_sys.status   = ck_ff.hold;
      nxt_sys.cfg_send = sys_ff.cfg;
      nxt_sys.req_tgl  = !sys_ff.req_tgl;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sys_ff          <= '0;
      sys_ff.cfg      <= CFG_RST;
      sys_ff.cfg_send <= CFG_RST;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  odt_sync u_req_sync (
    .i_clk   (I_CK),
    .i_rst_n (I_RST_N),
    .i_d     (sys_ff.req_tgl),
    .o_q     (req_sync)
  );

  odt_sync u_ack_sync (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .i_d     (ck_ff.ack_tgl),
    .o_q     (ack_sync)
  );

  // Link domain: latencies, windows and the priority resolution.
  assign nom_en    = (ck_ff.cfg.rtt_nom != 3'h0);
  assign wr_en     = (ck_ff.cfg.rtt_wr != 2'h0);
  assign park_en   = (ck_ff.cfg.rtt_park != 3'h0);
  assign pre_x     = ck_ff.cfg.preamble2 ? PRE_X_2TCK : PRE_X_1TCK;
  assign burst_len = (ck_ff.cfg.bl8 ? HALF_BL8 : HALF_BC4) + {2'h0, pre_x};
  assign odt_lat   = sat_sub(ck_ff.cfg.wl, pre_x);
  assign rd_lat    = sat_sub(ck_ff.cfg.rl, pre_x);

  // The pin receiver is off while nominal is disabled or the device self-refreshes.
  assign O_ODT_RX_EN = nom_en && !ck_ff.cfg.self_refresh;

  odt_window u_nom_win (
    .i_clk    (I_CK),
    .i_rst_n  (I_RST_N),
    .i_event  (I_ODT && O_ODT_RX_EN),
    .i_lat    (odt_lat),
    .i_len    (4'h1),
    .o_active (nom_on)
  );

  odt_window u_wr_win (
    .i_clk    (I_CK),
    .i_rst_n  (I_RST_N),
    .i_event  (I_CMD_WRITE),
    .i_lat    (odt_lat),
    .i_len    (burst_len),
    .o_active (wr_on)
  );

  odt_window u_rd_win (
    .i_clk    (I_CK),
    .i_rst_n  (I_RST_N),
    .i_event  (I_CMD_READ),
    .i_lat    (rd_lat),
    .i_len    (burst_len),
    .o_active (rd_off)
  );

  always_comb begin
    nxt_ck = ck_ff;
    if (req_sync != ck_ff.ack_tgl) begin
      nxt_ck.cfg     = sys_ff.cfg_send;
      nxt_ck.hold    = '{onehot: {O_TERM_PARK, O_TERM_NOM, O_TERM_WR, O_TERM_HIZ},
                         code: ck_ff.code, rx_en: O_ODT_RX_EN};
      nxt_ck.ack_tgl = !ck_ff.ack_tgl;
    end
    // Resolved on every edge; earlier branches take precedence.
    if (ck_ff.cfg.self_refresh) begin
      nxt_ck.sel  = TERM_HIZ;
      nxt_ck.code = 3'h0;
    end else if (rd_off) begin
      nxt_ck.sel  = TERM_HIZ;
      nxt_ck.code = 3'h0;
    end else if (wr_en && wr_on) begin
      nxt_ck.sel  = TERM_WR;
      nxt_ck.code = {1'b0, ck_ff.cfg.rtt_wr};
    end else if (nom_en && nom_on) begin
      nxt_ck.sel  = TERM_NOM;
      nxt_ck.code = ck_ff.cfg.rtt_nom;
    end else if (park_en) begin
      nxt_ck.sel  = TERM_PARK;
      nxt_ck.code = ck_ff.cfg.rtt_park;
    end else begin
      nxt_ck.sel  = TERM_HIZ;
      nxt_ck.code = 3'h0;
    end
    nxt_ck.tdqs = ck_ff.cfg.tdqs_en && (nxt_ck.sel != TERM_HIZ);
  end

  always_ff @(posedge I_CK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ck_ff     <= '0;
      ck_ff.cfg <= CFG_RST;
      ck_ff.sel <= TERM_HIZ;
    end else begin
      ck_ff <= nxt_ck;
    end
  end

  assign O_TERM_HIZ  = (ck_ff.sel == TERM_HIZ);
  assign O_TERM_WR   = (ck_ff.sel == TERM_WR);
  assign O_TERM_NOM  = (ck_ff.sel == TERM_NOM);
  assign O_TERM_PARK = (ck_ff.sel == TERM_PARK);
  assign O_RTT_CODE  = ck_ff.code;
  assign O_TDQS_TERM = ck_ff.tdqs;

endmodule

// file: rtl/odt_pkg.sv
// Package with the register map, field layouts and types of the termination controller.
package odt_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_RTT    = 8'h04;
  localparam logic [7:0] OFS_LAT    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Field positions of the control register.
  localparam int CTRL_SELF_REFRESH = 0;
  localparam int CTRL_TDQS_EN      = 1;
  localparam int CTRL_PREAMBLE2    = 2;
  localparam int CTRL_BL8          = 3;

  // Field positions of the resistance register.
  localparam int RTT_NOM_LSB  = 0;
  localparam int RTT_WR_LSB   = 4;
  localparam int RTT_PARK_LSB = 8;

  // Field positions of the latency register.
  localparam int LAT_WL_LSB = 0;
  localparam int LAT_RL_LSB = 8;

  // Values after reset.
  localparam logic [3:0] CTRL_RST     = 4'h0;
  localparam logic [2:0] RTT_NOM_RST  = 3'h0;
  localparam logic [1:0] RTT_WR_RST   = 2'h0;
  localparam logic [2:0] RTT_PARK_RST = 3'h0;
  localparam logic [5:0] WL_RST       = 6'h09;
  localparam logic [5:0] RL_RST       = 6'h0b;

  // Preamble dependent offset and half burst lengths in clock cycles.
  localparam logic [1:0] PRE_X_1TCK = 2'h2;
  localparam logic [1:0] PRE_X_2TCK = 2'h3;
  localparam logic [3:0] HALF_BC4   = 4'h2;
  localparam logic [3:0] HALF_BL8   = 4'h4;

  // Depth of the command and pin history in link clock cycles.
  localparam int HIST_DEPTH = 72;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Termination state that the lanes present.
  typedef enum logic [1:0] {
    TERM_HIZ  = 2'b00,
    TERM_WR   = 2'b01,
    TERM_NOM  = 2'b10,
    TERM_PARK = 2'b11
  } term_sel_t;

  // Configuration word passed to the link domain.
  typedef struct packed {
    logic       self_refresh;
    logic       tdqs_en;
    logic       preamble2;
    logic       bl8;
    logic [2:0] rtt_nom;
    logic [1:0] rtt_wr;
    logic [2:0] rtt_park;
    logic [5:0] wl;
    logic [5:0] rl;
  } cfg_t;

  localparam cfg_t CFG_RST = '{self_refresh: 1'b0, tdqs_en: 1'b0, preamble2: 1'b0,
                               bl8: 1'b0, rtt_nom: 3'h0, rtt_wr: 2'h0, rtt_park: 3'h0,
                               wl: 6'h09, rl: 6'h0b};

  // Status word passed back to the register domain.
  typedef struct packed {
    logic [3:0] onehot;
    logic [2:0] code;
    logic       rx_en;
  } stat_t;

endpackage

// file: rtl/odt_sync.sv
// Two flip-flop synchroniser for a single level.
module odt_sync
  import odt_pkg::*;
(
  // Clock and reset.
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Level in and synchronised level out.
  input  wire logic i_d,
  output logic      o_q
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_st_t;

  sync_st_t st_ff;
  sync_st_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = i_d;
    nxt_st.sync = st_ff.meta;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_q = st_ff.sync;

endmodule

// file: rtl/odt_window.sv
// Event history that reports a window opening a set delay after each event.
module odt_window
  import odt_pkg::*;
(
  // Link clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // Event sampled each edge, delay to the window and its length.
  input  wire logic       i_event,
  input  wire logic [5:0] i_lat,
  input  wire logic [3:0] i_len,
  // High while any past event has its window open.
  output logic            o_active
);

  typedef struct packed {
    logic [HIST_DEPTH-1:0] hist;
    logic                  active;
  } win_st_t;

  win_st_t st_ff;
  win_st_t nxt_st;

  // Index j of ext holds the event seen j edges before the present one.
  function automatic logic window_hit(input logic [HIST_DEPTH:0] ext,
                                      input logic [5:0] lat, input logic [3:0] len);
    logic hit;
    hit = 1'b0;
    for (int j = 0; j <= HIST_DEPTH; j++) begin
      if ((j >= int'(lat)) && (j < int'(lat) + int'(len)) && ext[j]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.hist   = {st_ff.hist[HIST_DEPTH-2:0], i_event};
    nxt_st.active = window_hit({st_ff.hist, i_event}, i_lat, i_len);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_active = st_ff.active;

endmodule
